// file: card_host_model.sv
/*
 * Host model on the command line: clocks frames, sends commands,
 * collects responses and can pull the line low like a rival card.
 * Assumes a pull-up on the line and open-drain or push-pull card pin.
 */
`timescale 1ns/1ps
`default_nettype none
module card_host_model (
    // Link clock and resolved line
    output logic card_clk,
    output logic cmd_line,
    // Card pin
    input wire logic cmd_out,
    input wire logic cmd_oe
);
    logic h_low;
    logic [135:0] resp;
    int got;
    int pull_at;
    // Clock stands low outside frames
    initial begin
        card_clk = 1'b0;
        h_low = 1'b0;
        pull_at = -1;
        resp = '0;
        got = 0;
    end
    // Wired-AND line, released level is high
    assign cmd_line = ~(h_low | (cmd_oe & ~cmd_out));
    ////////////////////////////////////////
    // One link clock period
    task tick;
        #7.5 card_clk = 1'b1;
        #7.5 card_clk = 1'b0;
    endtask : tick
    // Frame checksum
    function automatic logic [6:0] crc_calc(input logic [39:0] d);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 39; i >= 0; i--) begin
            c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
        end
        return c;
    endfunction : crc_calc
    // Idle bits, frame MSB first, then up to n response bits
    task send(input logic [5:0] idx, input logic [31:0] arg, input int n);
        logic [47:0] f;
        f = {2'b01, idx, arg, crc_calc({2'b01, idx, arg}), 1'b1};
        resp = '0;
        got = 0;
        repeat (4) tick();
        for (int i = 47; i >= 0; i--) begin
            h_low = ~f[i];
            tick();
        end
        h_low = 1'b0;
        for (int k = 0; k < 200 && got < n; k++) begin
            h_low = (got == pull_at);
            #7.5;
            if (got > 0 || cmd_line == 1'b0) begin
                resp = {resp[134:0], cmd_line};
                got++;
            end
            card_clk = 1'b1;
            #7.5 card_clk = 1'b0;
        end
        h_low = 1'b0;
        repeat (2) tick();
    endtask : send
endmodule : card_host_model
`default_nettype wire

// file: card_id_boot.sv
/*
 * Card-side identification phase on the command line plus boot bus width
 * selection.
 * Assumes: cmd_in is the resolved command line, sampled on the host's
 * card_clk; boot_active and the config byte port come from mclk logic.
 */
`timescale 1ns/1ps
`default_nettype none

module card_id_boot
    import card_id_pkg::*;
#(
    parameter int unsigned POWERUP_CYCLES = POWERUP_CYCLES_DEF,
    parameter logic [127:0] CARD_IDENTITY = 128'h0123456789ABCDEF0F1E2D3C4B5A6979,
    parameter logic HIGH_CAPACITY = 1'b1,
    parameter logic [23:0] VDD_WINDOW = 24'hFF8000
) (
    // System clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Boot engine status
    input wire logic boot_active,
    // Configuration byte access
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // Data bus width and init status
    output logic [1:0] data_width,
    output logic init_busy,
    // Command line on the link clock
    input wire logic card_clk,
    input wire logic cmd_in,
    output logic cmd_out,
    output logic cmd_oe,
    // Card status on the link clock
    output card_state_t card_state,
    output logic [15:0] relative_card_address,
    output logic [15:0] dsr,
    output logic push_pull,
    output logic sector_mode
);

    //////////////////////////////////////////////////////////////////////////
    // Link reset: asserted at once, released on the link clock
    logic link_rst_s1_ff;
    logic link_rst_n_ff;

    always_ff @(posedge card_clk or negedge arst_n) begin
        if (!arst_n) begin
            link_rst_s1_ff <= 1'b0;
            link_rst_n_ff <= 1'b0;
        end else begin
            link_rst_s1_ff <= 1'b1;
            link_rst_n_ff <= link_rst_s1_ff;
        end
    end

    link_state_t link_ff;
    link_state_t nxt_link;
    core_state_t core_ff;
    core_state_t nxt_core;

    //////////////////////////////////////////////////////////////////////////
    // Received frame view and decode helpers
    logic [47:0] frame_bits;
    cmd_frame_t frame;
    logic frm_done;
    logic frm_ok;
    logic is_reset_cmd;
    logic is_op_cmd;
    logic is_addr_cmd;
    logic id_bit_lost;

    assign frame_bits = {link_ff.shreg[46:0], cmd_in};
    assign frame = cmd_frame_t'(frame_bits);
    assign frm_done = (link_ff.phase == PH_RECV) && (link_ff.cnt == CMD_BITS - 8'h01);
    // Start, direction, end bit and checksum all must hold
    assign frm_ok = frm_done && !frame.start && frame.dir && frame.stop
        && (crc7(frame_bits[47:8]) == frame.crc);
    assign is_reset_cmd = frm_ok && (frame.index == CMD_GO_IDLE) && (frame.arg != BOOT_ARG)
        && (link_ff.card != CS_INACTIVE);
    assign is_op_cmd = frm_ok && (frame.index == CMD_OP_COND) && (link_ff.card == CS_IDLE);
    assign is_addr_cmd = frm_ok && (frame.index == CMD_SET_ADDR) && (link_ff.card == CS_IDENT);
    // Released line pulled low by another card during identity send
    assign id_bit_lost = (link_ff.phase == PH_SEND) && link_ff.is_id && !link_ff.push_pull
        && link_ff.shreg[135] && !cmd_in;

    //////////////////////////////////////////////////////////////////////////
    // Link side: receive, decode, respond
    always_comb begin
        logic host_sec;
        logic vdd;
        logic [31:0] operating_conditions_register;
        host_sec = 1'b0;
        vdd = 1'b0;
        operating_conditions_register = 32'h00000000;
        nxt_link = link_ff;
        nxt_link.busy_s1 = core_ff.busy;
        nxt_link.busy_s2 = link_ff.busy_s1;
        unique case (link_ff.phase)
            PH_LISTEN: begin
                nxt_link.cmd_oe = 1'b0;
                nxt_link.cmd_out = 1'b0;
                // Only the command line is watched for traffic
                if (!cmd_in) begin
                    nxt_link.phase = PH_RECV;
                    nxt_link.cnt = 8'h01;
                    nxt_link.shreg = '0;
                end
            end
            PH_RECV: begin
                nxt_link.shreg = {link_ff.shreg[134:0], cmd_in};
                nxt_link.cnt = link_ff.cnt + 8'h01;
                if (frm_done) begin
                    nxt_link.phase = PH_LISTEN;
                    nxt_link.is_id = 1'b0;
                end
                // Inactive card ignores everything until power cycle
                if (is_reset_cmd) begin
                    nxt_link.card = CS_IDLE;
                    nxt_link.relative_card_address = RCA_DEFAULT;
                    nxt_link.dsr = DSR_DEFAULT;
                    nxt_link.push_pull = 1'b0;
                    nxt_link.sector_mode = 1'b0;
                    nxt_link.acc_locked = 1'b0;
                    nxt_link.host_sector = 1'b0;
                    nxt_link.vdd_ok = 1'b0;
                    nxt_link.rst_tgl = ~link_ff.rst_tgl;
                end else if (is_op_cmd) begin
                    // First command of the sequence fixes the conditions
                    host_sec = link_ff.acc_locked ? link_ff.host_sector
                        : (frame.arg[ACCESS_MSB:ACCESS_LSB] == ACCESS_SECTOR);
                    vdd = link_ff.acc_locked ? link_ff.vdd_ok
                        : |(frame.arg[23:0] & VDD_WINDOW);
                    nxt_link.acc_locked = 1'b1;
                    nxt_link.host_sector = host_sec;
                    nxt_link.vdd_ok = vdd;
                    if (!vdd || (HIGH_CAPACITY && !host_sec)) begin
                        nxt_link.card = CS_INACTIVE;
                    end else begin
                        // Ready bit low and access bits zero while busy
                        operating_conditions_register = {~link_ff.busy_s2, 7'h00, VDD_WINDOW};
                        if (!link_ff.busy_s2 && HIGH_CAPACITY) begin
                            operating_conditions_register[ACCESS_MSB:ACCESS_LSB] = ACCESS_SECTOR;
                        end
                        nxt_link.phase = PH_GAP;
                        nxt_link.cnt = RESP_GAP;
                        nxt_link.shreg = {2'b00, IDX_NONE, operating_conditions_register, CRC_NONE, 1'b1, 88'h0};
                        if (!link_ff.busy_s2) begin
                            nxt_link.card = CS_READY;
                            nxt_link.sector_mode = HIGH_CAPACITY;
                        end
                    end
                end else if (frm_ok && frame.index == CMD_ALL_ID && link_ff.card == CS_READY) begin
                    nxt_link.phase = PH_GAP;
                    nxt_link.cnt = RESP_GAP;
                    nxt_link.is_id = 1'b1;
                    nxt_link.shreg = {2'b00, IDX_NONE, CARD_IDENTITY[127:1], 1'b1};
                end else if (is_addr_cmd) begin
                    nxt_link.relative_card_address = frame.arg[31:16];
                    nxt_link.card = CS_STBY;
                    nxt_link.push_pull = 1'b1;
                    nxt_link.phase = PH_GAP;
                    nxt_link.cnt = RESP_GAP;
                    nxt_link.shreg = {resp48(CMD_SET_ADDR, STATUS_IDENT), 88'h0};
                end else if (frm_ok && frame.index == CMD_DEACT && link_ff.card == CS_STBY
                        && frame.arg[31:16] == link_ff.relative_card_address) begin
                    nxt_link.card = CS_INACTIVE;
                end
            end
            PH_GAP: begin
                if (link_ff.cnt == 8'h01) begin
                    nxt_link.phase = PH_SEND;
                    nxt_link.cnt = link_ff.is_id ? ID_RESP_BITS : SHORT_RESP_BITS;
                    nxt_link.cmd_oe = line_oe(link_ff.push_pull, link_ff.shreg[135]);
                    nxt_link.cmd_out = link_ff.push_pull & link_ff.shreg[135];
                end else begin
                    nxt_link.cnt = link_ff.cnt - 8'h01;
                end
            end
            PH_SEND: begin
                if (id_bit_lost) begin
                    // Lost arbitration: release at once, stay Ready
                    nxt_link.phase = PH_LISTEN;
                    nxt_link.cmd_oe = 1'b0;
                    nxt_link.cmd_out = 1'b0;
                    nxt_link.is_id = 1'b0;
                end else if (link_ff.cnt == 8'h01) begin
                    nxt_link.phase = PH_LISTEN;
                    nxt_link.cmd_oe = 1'b0;
                    nxt_link.cmd_out = 1'b0;
                    nxt_link.is_id = 1'b0;
                    if (link_ff.is_id) begin
                        nxt_link.card = CS_IDENT;
                    end
                end else begin
                    nxt_link.shreg = {link_ff.shreg[134:0], 1'b0};
                    nxt_link.cnt = link_ff.cnt - 8'h01;
                    nxt_link.cmd_oe = line_oe(link_ff.push_pull, link_ff.shreg[134]);
                    nxt_link.cmd_out = link_ff.push_pull & link_ff.shreg[134];
                end
            end
        endcase
    end

    // Link state register; power-on lands in Idle with drivers off
    always_ff @(posedge card_clk or negedge link_rst_n_ff) begin
        if (!link_rst_n_ff) begin
            link_ff <= LINK_RESET;
        end else begin
            link_ff <= nxt_link;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // System side: config byte, boot width, power-up busy timer
    always_comb begin
        nxt_core = core_ff;
        nxt_core.tgl_s1 = link_ff.rst_tgl;
        nxt_core.tgl_s2 = core_ff.tgl_s1;
        nxt_core.tgl_s3 = core_ff.tgl_s2;
        nxt_core.cfg_rdata = (cfg_addr == BOOT_CFG_OFFSET) ? core_ff.cfg : 8'h00;
        if (cfg_wr && cfg_addr == BOOT_CFG_OFFSET) begin
            nxt_core.cfg = cfg_wdata;
        end
        // Software reset restarts the internal power-up procedure
        if (core_ff.tgl_s2 != core_ff.tgl_s3) begin
            nxt_core.busy_cnt = 16'h0000;
            nxt_core.busy = 1'b1;
        end else if (core_ff.busy) begin
            if (core_ff.busy_cnt == 16'(POWERUP_CYCLES - 1)) begin
                nxt_core.busy = 1'b0;
            end else begin
                nxt_core.busy_cnt = core_ff.busy_cnt + 16'h0001;
            end
        end
        // Width follows config during boot, then bit 2 decides
        if (boot_active) begin
            nxt_core.width = width_decode(core_ff.cfg[WIDTH_SEL_MSB:WIDTH_SEL_LSB]);
            nxt_core.boot_seen = 1'b1;
        end else if (core_ff.boot_seen && core_ff.cfg[KEEP_WIDTH_BIT]) begin
            nxt_core.width = width_decode(core_ff.cfg[WIDTH_SEL_MSB:WIDTH_SEL_LSB]);
        end else begin
            nxt_core.width = BUS_X1;
        end
    end

    // System state register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            core_ff <= CORE_RESET;
        end else begin
            core_ff <= nxt_core;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs
    assign cfg_rdata = core_ff.cfg_rdata;
    assign data_width = core_ff.width;
    assign init_busy = core_ff.busy;
    assign cmd_out = link_ff.cmd_out;
    assign cmd_oe = link_ff.cmd_oe;
    assign card_state = link_ff.card;
    assign relative_card_address = link_ff.relative_card_address;
    assign dsr = link_ff.dsr;
    assign push_pull = link_ff.push_pull;
    assign sector_mode = link_ff.sector_mode;

    //////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_last_id_bit;
        (link_ff.phase == PH_SEND) && link_ff.is_id && (link_ff.cnt == 8'h01) && !id_bit_lost;
    endsequence

    sequence s_addr_taken;
        is_addr_cmd ##1 (link_ff.card == CS_STBY);
    endsequence

    chk_idle_reset: assert property (
        @(posedge card_clk) disable iff (!link_rst_n_ff)
        is_reset_cmd |=> link_ff.card == CS_IDLE
    ) else $error("software reset did not reach idle");

    chk_reset_defaults: assert property (
        @(posedge card_clk) disable iff (!link_rst_n_ff)
        is_reset_cmd |=> (link_ff.relative_card_address == RCA_DEFAULT) && !link_ff.push_pull && !cmd_oe
    ) else $error("reset defaults not loaded");

    chk_inactive_sticky: assert property (
        @(posedge card_clk) disable iff (!link_rst_n_ff)
        (link_ff.card == CS_INACTIVE) |=> (link_ff.card == CS_INACTIVE) && !cmd_oe
    ) else $error("inactive card left inactive state");

    chk_host_gate: assert property (
        @(posedge card_clk) disable iff (!link_rst_n_ff)
        is_op_cmd && HIGH_CAPACITY && !link_ff.acc_locked
            && (frame.arg[ACCESS_MSB:ACCESS_LSB] != ACCESS_SECTOR)
        |=> link_ff.card == CS_INACTIVE
    ) else $error("large card accepted byte-only host");

    chk_busy_idle: assert property (
        @(posedge card_clk) disable iff (!link_rst_n_ff)
        is_op_cmd && link_ff.busy_s2 |=> (link_ff.card != CS_READY)
            && ((link_ff.phase != PH_GAP) || !link_ff.shreg[127])
    ) else $error("card went ready while busy");

    chk_od_drive: assert property (
        @(posedge card_clk) disable iff (!link_rst_n_ff)
        cmd_oe && !link_ff.push_pull |-> !cmd_out
    ) else $error("open-drain pin drove high");

    chk_arb_stop: assert property (
        @(posedge card_clk) disable iff (!link_rst_n_ff)
        id_bit_lost |=> (!cmd_oe && (link_ff.card == CS_READY)) [*2]
    ) else $error("losing card kept driving");

    chk_id_win: assert property (
        @(posedge card_clk) disable iff (!link_rst_n_ff)
        s_last_id_bit |=> (link_ff.card == CS_IDENT) && !cmd_oe
    ) else $error("winning card not in identification");

    chk_rca_store: assert property (
        @(posedge card_clk) disable iff (!link_rst_n_ff)
        s_addr_taken |-> (link_ff.relative_card_address == $past(frame.arg[31:16], 1)) && link_ff.push_pull
    ) else $error("relative address not stored");

    chk_boot_width: assert property (
        @(posedge mclk) disable iff (!arst_n)
        boot_active |=> data_width == width_decode($past(core_ff.cfg[1:0], 1))
    ) else $error("boot width differs from config");

    chk_no_boot_x1: assert property (
        @(posedge mclk) disable iff (!arst_n)
        !core_ff.boot_seen && !boot_active |=> data_width == BUS_X1
    ) else $error("width not single line without boot");

endmodule : card_id_boot

`default_nettype wire

// file: card_id_pkg.sv
/*
 * Shared constants, types and helper functions for the card identification
 * and boot bus width block.
 * Assumes one system clock (mclk) and one host-driven link clock on the
 * command line; both files import this package whole.
 */
package card_id_pkg;

    //////////////////////////////////////////////////////////////////////////
    // Boot bus width configuration byte
    localparam logic [7:0] BOOT_CFG_OFFSET = 8'hB1;
    localparam logic [7:0] BOOT_CFG_RESET = 8'h00;
    localparam int WIDTH_SEL_LSB = 0;
    localparam int WIDTH_SEL_MSB = 1;
    localparam int KEEP_WIDTH_BIT = 2;
    localparam logic [1:0] BUS_X1 = 2'h0;
    localparam logic [1:0] BUS_X4 = 2'h1;
    localparam logic [1:0] BUS_X8 = 2'h2;

    //////////////////////////////////////////////////////////////////////////
    // Card defaults after power-on or software reset
    localparam logic [15:0] RCA_DEFAULT = 16'h0001;
    localparam logic [15:0] DSR_DEFAULT = 16'h0404;

    //////////////////////////////////////////////////////////////////////////
    // Command indices and frame constants
    localparam logic [5:0] CMD_GO_IDLE = 6'h00;
    localparam logic [5:0] CMD_OP_COND = 6'h01;
    localparam logic [5:0] CMD_ALL_ID = 6'h02;
    localparam logic [5:0] CMD_SET_ADDR = 6'h03;
    localparam logic [5:0] CMD_DEACT = 6'h0F;
    localparam logic [5:0] IDX_NONE = 6'h3F;
    localparam logic [6:0] CRC_NONE = 7'h7F;
    localparam logic [31:0] BOOT_ARG = 32'hFFFFFFFF;
    localparam logic [31:0] STATUS_IDENT = 32'h00000500;
    localparam logic [1:0] ACCESS_SECTOR = 2'h2;
    localparam logic [1:0] ACCESS_BYTE = 2'h0;
    localparam int ACCESS_MSB = 30;
    localparam int ACCESS_LSB = 29;
    localparam logic [7:0] CMD_BITS = 8'h30;
    localparam logic [7:0] SHORT_RESP_BITS = 8'h30;
    localparam logic [7:0] ID_RESP_BITS = 8'h88;
    localparam logic [7:0] RESP_GAP = 8'h02;

    //////////////////////////////////////////////////////////////////////////
    // Power-up procedure time
    localparam int CLK_MHZ = 40;
    localparam int POWERUP_US = 1000;
    localparam int POWERUP_CYCLES_DEF = POWERUP_US * CLK_MHZ;

    //////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [4:0] {
        CS_IDLE = 5'h01,
        CS_READY = 5'h02,
        CS_IDENT = 5'h04,
        CS_STBY = 5'h08,
        CS_INACTIVE = 5'h10
    } card_state_t;

    typedef enum logic [3:0] {
        PH_LISTEN = 4'h1,
        PH_RECV = 4'h2,
        PH_GAP = 4'h4,
        PH_SEND = 4'h8
    } phase_t;

    typedef struct packed {
        logic start;
        logic dir;
        logic [5:0] index;
        logic [31:0] arg;
        logic [6:0] crc;
        logic stop;
    } cmd_frame_t;

    typedef struct packed {
        card_state_t card;
        phase_t phase;
        logic [7:0] cnt;
        logic [135:0] shreg;
        logic is_id;
        logic [15:0] relative_card_address;
        logic [15:0] dsr;
        logic push_pull;
        logic sector_mode;
        logic acc_locked;
        logic host_sector;
        logic vdd_ok;
        logic rst_tgl;
        logic busy_s1;
        logic busy_s2;
        logic cmd_out;
        logic cmd_oe;
    } link_state_t;

    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] cfg_rdata;
        logic [1:0] width;
        logic boot_seen;
        logic [15:0] busy_cnt;
        logic busy;
        logic tgl_s1;
        logic tgl_s2;
        logic tgl_s3;
    } core_state_t;

    localparam link_state_t LINK_RESET = '{card: CS_IDLE, phase: PH_LISTEN, cnt: 8'h00,
        shreg: '0, is_id: 1'b0, relative_card_address: RCA_DEFAULT, dsr: DSR_DEFAULT, push_pull: 1'b0,
        sector_mode: 1'b0, acc_locked: 1'b0, host_sector: 1'b0, vdd_ok: 1'b0,
        rst_tgl: 1'b0, busy_s1: 1'b1, busy_s2: 1'b1, cmd_out: 1'b0, cmd_oe: 1'b0};

    localparam core_state_t CORE_RESET = '{cfg: BOOT_CFG_RESET, cfg_rdata: 8'h00,
        width: BUS_X1, boot_seen: 1'b0, busy_cnt: 16'h0000, busy: 1'b1,
        tgl_s1: 1'b0, tgl_s2: 1'b0, tgl_s3: 1'b0};

    //////////////////////////////////////////////////////////////////////////
    // Checksum over the first 40 bits of a frame, polynomial x^7 + x^3 + 1
    function automatic logic [6:0] crc7(input logic [39:0] d);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        fb = 1'b0;
        for (int i = 39; i >= 0; i--) begin
            fb = d[i] ^ c[6];
            c = {c[5:0], 1'b0};
            c[0] = fb;
            c[3] = c[3] ^ fb;
        end
        return c;
    endfunction : crc7

    // Complete short response frame with checksum
    function automatic logic [47:0] resp48(input logic [5:0] idx, input logic [31:0] arg);
        return {2'b00, idx, arg, crc7({2'b00, idx, arg}), 1'b1};
    endfunction : resp48

    // Reserved width code falls back to single line
    function automatic logic [1:0] width_decode(input logic [1:0] sel);
        return (sel == BUS_X4 || sel == BUS_X8) ? sel : BUS_X1;
    endfunction : width_decode

    // Pin enable: push-pull drives always, open-drain only pulls low
    function automatic logic line_oe(input logic pp, input logic bit_val);
        return pp | ~bit_val;
    endfunction : line_oe

endpackage : card_id_pkg

// file: tb.sv
/*
 * Testbench: config port and boot flag on mclk, identification run
 * through the host model. Assumes a shortened power-up time.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import card_id_pkg::*;
    localparam logic [127:0] ID = 128'h0123456789ABCDEF0F1E2D3C4B5A6979; // Arbitrary
    localparam logic [31:0] A_SEC = 32'h40FF8000;
    localparam logic [31:0] A_BYTE = 32'h00FF8000;
    logic mclk, arst_n, boot_active, cfg_wr, init_busy, card_clk, cmd_in, cmd_out, cmd_oe;
    logic push_pull, sector_mode;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, rv;
    logic [1:0] data_width;
    logic [15:0] relative_card_address, dsr;
    card_state_t card_state;
    int miscompares, samples_checked;
    card_id_boot #(.POWERUP_CYCLES(200), .CARD_IDENTITY(ID)) dut (.mclk(mclk),
        .arst_n(arst_n), .boot_active(boot_active), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .data_width(data_width),
        .init_busy(init_busy), .card_clk(card_clk), .cmd_in(cmd_in), .cmd_out(cmd_out),
        .cmd_oe(cmd_oe), .card_state(card_state), .relative_card_address(relative_card_address), .dsr(dsr),
        .push_pull(push_pull), .sector_mode(sector_mode));
    card_host_model host (.card_clk(card_clk), .cmd_line(cmd_in), .cmd_out(cmd_out),
        .cmd_oe(cmd_oe));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    ////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task results;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge mclk);
        cfg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        cfg_addr <= a;
        repeat (2) @(posedge mclk);
        #1 check(cfg_rdata, exp);
    endtask : rd
    // Width while booting and after boot ends
    task boot(input logic [7:0] cfg, input logic [1:0] during, input logic [1:0] after);
        wr(BOOT_CFG_OFFSET, cfg);
        boot_active <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 check(data_width, during);
        boot_active <= 1'b0;
        repeat (3) @(posedge mclk);
        #1 check(data_width, after);
    endtask : boot
    task do_reset;
        arst_n <= 1'b0;
        repeat (3) host.tick();
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        #1 check(card_state, CS_IDLE);
        check({relative_card_address, dsr}, {RCA_DEFAULT, DSR_DEFAULT});
        check({cmd_oe, push_pull, init_busy}, 3'b001);
    endtask : do_reset
    // Repeat the condition command until not busy
    task op_ready(input logic [31:0] arg);
        int k;
        k = 0;
        do begin
            host.send(CMD_OP_COND, arg, 48);
            k++;
        end while (host.resp[39] !== 1'b1 && k < 30);
    endtask : op_ready
    ////////////////////////////////////////
    initial begin
        arst_n = 1'b0;
        boot_active = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
        miscompares = 0;
        samples_checked = 0;
        do_reset();
        check(data_width, BUS_X1);
        rd(BOOT_CFG_OFFSET, BOOT_CFG_RESET);
        wr(8'hB0, 8'h55);
        rd(8'hB0, 8'h00);
        boot(8'h06, BUS_X8, BUS_X8);
        boot(8'h01, BUS_X4, BUS_X1);
        $display("test config and boot done");
        host.send(CMD_OP_COND, A_SEC, 48);
        check({host.resp[39], card_state}, {1'b0, CS_IDLE});
        op_ready(A_BYTE);
        check(card_state, CS_READY);
        check({host.resp[38:37], sector_mode}, 3'b101);
        host.send(CMD_GO_IDLE, 32'h0, 0);
        check(card_state, CS_IDLE);
        op_ready(A_SEC);
        host.pull_at = 15;
        host.send(CMD_ALL_ID, 32'h0, 136);
        check(card_state, CS_READY);
        host.pull_at = -1;
        host.send(CMD_ALL_ID, 32'h0, 136);
        check(host.resp[127:1] === ID[127:1], 1'b1);
        check(card_state, CS_IDENT);
        host.send(CMD_SET_ADDR, 32'h12340000, 48);
        check({host.resp[47:40], host.resp[0]}, {2'b00, CMD_SET_ADDR, 1'b1});
        check(host.resp[7:1], host.crc_calc({2'b00, CMD_SET_ADDR, STATUS_IDENT}));
        check({relative_card_address, push_pull}, {16'h1234, 1'b1});
        host.send(CMD_ALL_ID, 32'h0, 136);
        check(host.got, 0);
        host.send(CMD_DEACT, 32'h55550000, 0);
        check(card_state, CS_STBY);
        host.send(CMD_DEACT, 32'h12340000, 0);
        host.send(CMD_GO_IDLE, 32'h0, 0);
        check(card_state, CS_INACTIVE);
        $display("test identification done");
        do_reset();
        host.send(CMD_OP_COND, A_BYTE, 48);
        check(host.got, 0);
        check(card_state, CS_INACTIVE);
        $display("test access refusal done");
        results();
    end
    initial begin
        #400000;
        miscompares++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        results();
    end
endmodule : tb
`default_nettype wire
